// >>> pbcm_pkg.sv
// package: register map, field layout and reset values of the peripheral bus clock mask
package pbcm_pkg;
	localparam logic [11:0] PBCM_OFS_BRIDGE_B = 12'h0018;
	localparam logic [11:0] PBCM_OFS_BRIDGE_C = 12'h001c;
	localparam logic [11:0] PBCM_OFS_BRIDGE_D = 12'h0020;
	localparam int PBCM_B_BITS = 3;
	localparam int PBCM_C_BITS = 15;
	localparam int PBCM_D_BITS = 8;
	localparam int PBCM_N_CLK = PBCM_B_BITS + PBCM_C_BITS + PBCM_D_BITS;
	localparam logic [31:0] PBCM_RST_BRIDGE_B = 32'h0000_0007;
	localparam logic [31:0] PBCM_RST_BRIDGE_C = 32'h0000_7fff;
	localparam logic [31:0] PBCM_RST_BRIDGE_D = 32'h0000_00ff;
	localparam logic [31:0] PBCM_MASK_BRIDGE_B = 32'h0000_0007;
	localparam logic [31:0] PBCM_MASK_BRIDGE_C = 32'h0000_7fff;
	localparam logic [31:0] PBCM_MASK_BRIDGE_D = 32'h0000_00ff;
	// bridge b fields
	localparam int PBCM_B_NVM_BIT = 2;
	localparam int PBCM_B_DSU_BIT = 1;
	localparam int PBCM_B_USB_BIT = 0;
	// bridge c fields
	localparam int PBCM_C_RNG_BIT = 14;
	localparam int PBCM_C_AES_BIT = 13;
	localparam int PBCM_C_DAC_BIT = 12;
	localparam int PBCM_C_TIMER_LO = 8;
	localparam int PBCM_C_CTIMER_LO = 5;
	localparam int PBCM_C_SERIAL_LO = 0;
	// bridge d fields
	localparam int PBCM_D_LOGIC_BIT = 7;
	localparam int PBCM_D_OP_AMP_BLOCK_BIT = 6;
	localparam int PBCM_D_TOUCH_BIT = 5;
	localparam int PBCM_D_COMP_BIT = 4;
	localparam int PBCM_D_ADC_BIT = 3;
	localparam int PBCM_D_TIMER4_BIT = 2;
	localparam int PBCM_D_SERIAL5_BIT = 1;
	localparam int PBCM_D_EVENT_BIT = 0;
	// apb request bundle
	typedef struct packed
	{
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pbcm_apb_req_t;
	// gate enables of all peripherals, bridge b low, then c, then d
	typedef struct packed
	{
		logic [PBCM_D_BITS-1:0] d;
		logic [PBCM_C_BITS-1:0] c;
		logic [PBCM_B_BITS-1:0] b;
	} pbcm_gate_t;
endpackage

// >>> pbcm_clock_gate.sv
// glitch-free latch-based clock gate for one peripheral bus clock
`timescale 1ns/1ps
`default_nettype none
module pbcm_clock_gate
(
	input wire logic clk,
	input wire logic en,
	output logic gclk
);
	logic en_latch;
	always_latch
	begin
		if (!clk)
		begin
			en_latch <= en;
		end
	end
	assign gclk = clk & en_latch;
endmodule // pbcm_clock_gate
`default_nettype wire

// >>> pbcm_top.sv
// peripheral bus clock mask: apb registers and gated bus clocks
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pbcm_top
	import pbcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [PBCM_N_CLK-1:0] periph_clk,
	output logic [PBCM_N_CLK-1:0] periph_clk_en
);
	////////////////////////////////////////////////////////////////////////////////
	// register state
	pbcm_apb_req_t req;
	logic [31:0] b_reg;
	logic [31:0] b_next;
	logic [31:0] c_reg;
	logic [31:0] c_next;
	logic [31:0] d_reg;
	logic [31:0] d_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [PBCM_N_CLK-1:0] en_reg;
	logic [PBCM_N_CLK-1:0] en_next;
	pbcm_gate_t gate;
	logic access;
	logic hit;

	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign access = req.sel & req.enable;
	assign hit = (req.addr == PBCM_OFS_BRIDGE_B) | (req.addr == PBCM_OFS_BRIDGE_C)
		| (req.addr == PBCM_OFS_BRIDGE_D);

	////////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	always_comb
	begin
		b_next = b_reg;
		c_next = c_reg;
		d_next = d_reg;
		prdata_next = 32'h0000_0000;
		pslverr_next = 1'b0;
		if (req.sel && !req.enable)
		begin
			pslverr_next = !hit;
			if (!req.write)
			begin
				unique case (req.addr)
					PBCM_OFS_BRIDGE_B: prdata_next = b_reg;
					PBCM_OFS_BRIDGE_C: prdata_next = c_reg;
					PBCM_OFS_BRIDGE_D: prdata_next = d_reg;
					default: prdata_next = 32'h0000_0000;
				endcase
			end
		end
		if (access && req.write)
		begin
			unique case (req.addr)
				PBCM_OFS_BRIDGE_B: b_next = req.wdata & PBCM_MASK_BRIDGE_B;
				PBCM_OFS_BRIDGE_C: c_next = req.wdata & PBCM_MASK_BRIDGE_C;
				PBCM_OFS_BRIDGE_D: d_next = req.wdata & PBCM_MASK_BRIDGE_D;
				default: b_next = b_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			b_reg <= PBCM_RST_BRIDGE_B;
			c_reg <= PBCM_RST_BRIDGE_C;
			d_reg <= PBCM_RST_BRIDGE_D;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			b_reg <= b_next;
			c_reg <= c_next;
			d_reg <= d_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// gate enables mapped per peripheral
	always_comb
	begin
		gate.b[PBCM_B_NVM_BIT] = b_reg[PBCM_B_NVM_BIT];
		gate.b[PBCM_B_DSU_BIT] = b_reg[PBCM_B_DSU_BIT];
		gate.b[PBCM_B_USB_BIT] = b_reg[PBCM_B_USB_BIT];
		gate.c[PBCM_C_RNG_BIT] = c_reg[PBCM_C_RNG_BIT];
		gate.c[PBCM_C_AES_BIT] = c_reg[PBCM_C_AES_BIT];
		gate.c[PBCM_C_DAC_BIT] = c_reg[PBCM_C_DAC_BIT];
		gate.c[PBCM_C_DAC_BIT-1:PBCM_C_TIMER_LO] = c_reg[PBCM_C_DAC_BIT-1:PBCM_C_TIMER_LO];
		gate.c[PBCM_C_TIMER_LO-1:PBCM_C_CTIMER_LO] = c_reg[PBCM_C_TIMER_LO-1:PBCM_C_CTIMER_LO];
		gate.c[PBCM_C_CTIMER_LO-1:PBCM_C_SERIAL_LO] = c_reg[PBCM_C_CTIMER_LO-1:PBCM_C_SERIAL_LO];
		gate.d[PBCM_D_LOGIC_BIT] = d_reg[PBCM_D_LOGIC_BIT];
		gate.d[PBCM_D_OP_AMP_BLOCK_BIT] = d_reg[PBCM_D_OP_AMP_BLOCK_BIT];
		gate.d[PBCM_D_TOUCH_BIT] = d_reg[PBCM_D_TOUCH_BIT];
		gate.d[PBCM_D_COMP_BIT] = d_reg[PBCM_D_COMP_BIT];
		gate.d[PBCM_D_ADC_BIT] = d_reg[PBCM_D_ADC_BIT];
		gate.d[PBCM_D_TIMER4_BIT] = d_reg[PBCM_D_TIMER4_BIT];
		gate.d[PBCM_D_SERIAL5_BIT] = d_reg[PBCM_D_SERIAL5_BIT];
		gate.d[PBCM_D_EVENT_BIT] = d_reg[PBCM_D_EVENT_BIT];
	end

	assign en_next = gate;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_reg <= {PBCM_N_CLK{1'b1}};
		end
		else
		begin
			en_reg <= en_next;
		end
	end

	assign periph_clk_en = en_reg;

	////////////////////////////////////////////////////////////////////////////////
	// one glitch-free gate per peripheral clock
	genvar gi;
	generate
		for (gi = 0; gi < PBCM_N_CLK; gi++)
		begin : g_gate
			pbcm_clock_gate u_gate
			(
				.clk(pclk),
				.en(en_reg[gi]),
				.gclk(periph_clk[gi])
			);
		end
	endgenerate
endmodule // pbcm_top
`default_nettype wire

// >>> pbcm_properties.sv
// checker: register and gated clock properties
`timescale 1ns/1ps
`default_nettype none
module pbcm_properties
	import pbcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [PBCM_N_CLK-1:0] periph_clk,
	input wire logic [PBCM_N_CLK-1:0] periph_clk_en
);
	logic w;
	logic r;
	logic hit;
	assign w = psel && penable && pwrite;
	assign r = psel && penable && !pwrite;
	assign hit = paddr inside {PBCM_OFS_BRIDGE_B, PBCM_OFS_BRIDGE_C, PBCM_OFS_BRIDGE_D};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////
	chk_b_en_follow: assert property (w && paddr == PBCM_OFS_BRIDGE_B
		|-> ##2 periph_clk_en[2:0] == $past(pwdata[2:0], 2)) else $error("b gate wrong");
	chk_c_en_follow: assert property (
		w && paddr == PBCM_OFS_BRIDGE_C
		|-> ##2 periph_clk_en[17:3] == $past(pwdata[14:0], 2)) else $error("c gate wrong");
	chk_d_en_follow: assert property (
		w && paddr == PBCM_OFS_BRIDGE_D
		|-> ##2 periph_clk_en[25:18] == $past(pwdata[7:0], 2)) else $error("d gate wrong");
	chk_b_rsv_zero: assert property (r && paddr == PBCM_OFS_BRIDGE_B
		|-> prdata[31:3] == 0) else $error("b reserved not zero");
	chk_bad_addr_err: assert property (psel && penable && !hit
		|-> pslverr && (pwrite || prdata == 0)) else $error("unmapped not refused");
	chk_good_addr_ok: assert property (psel && penable && hit
		|-> !pslverr) else $error("mapped refused");
	chk_gate_low: assert property (periph_clk == 0)
		else $error("gated clock high in low phase");
	chk_gate_match: assert property (@(negedge pclk) $stable(periph_clk_en)
		|-> periph_clk == periph_clk_en) else $error("gated clock pulse wrong");
endmodule // pbcm_properties
`default_nettype wire

// >>> pbcm_periph_model.sv
// peripheral side model: counts bus clock pulses per peripheral
`timescale 1ns/1ps
`default_nettype none
module pbcm_periph_model
	import pbcm_pkg::*;
(
	input wire logic [PBCM_N_CLK-1:0] periph_clk,
	output var int unsigned pulses [PBCM_N_CLK]
);
	for (genvar i = 0; i < PBCM_N_CLK; i++)
	begin : g_cnt
		initial pulses[i] = 0;
		always @(posedge periph_clk[i])
			pulses[i] <= pulses[i] + 1;
	end
endmodule // pbcm_periph_model
`default_nettype wire

// >>> pbcm_tb_top.sv
// bench: register rows, gated clock pulses and mid-run reset
`timescale 1ns/1ps
`default_nettype none
module pbcm_tb_top
	import pbcm_pkg::*;
;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} pbcm_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [PBCM_N_CLK-1:0] periph_clk, periph_clk_en;
	logic [31:0] ex [3];
	int unsigned pulses [PBCM_N_CLK], snap [PBCM_N_CLK];
	int err_total = 0, checks = 0;
	pbcm_row_t rows [7] = '{'{PBCM_OFS_BRIDGE_B, 32'h2, 32'h2, 1'b0},
		'{PBCM_OFS_BRIDGE_C, 32'h5555, 32'h5555, 1'b0},
		'{PBCM_OFS_BRIDGE_C, 32'h2aaa, 32'h2aaa, 1'b0},
		'{PBCM_OFS_BRIDGE_D, 32'h55, 32'h55, 1'b0}, '{PBCM_OFS_BRIDGE_D, 32'haa, 32'haa, 1'b0},
		'{PBCM_OFS_BRIDGE_B, 32'h5, 32'h5, 1'b0}, '{12'h024, 32'h1, 32'h0, 1'b1}};
	pbcm_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .periph_clk, .periph_clk_en);
	pbcm_periph_model peri_u (.periph_clk, .pulses);
	initial forever #2 pclk = ~pclk;
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic gates();
		logic [PBCM_N_CLK-1:0] en;
		en = {ex[2][7:0], ex[1][14:0], ex[0][2:0]};
		@(posedge pclk);
		#1 snap = pulses;
		repeat (4) @(posedge pclk);
		#1 cmp(32'(periph_clk_en), 32'(en));
		foreach (snap[j])
			cmp(pulses[j] - snap[j], en[j] ? 4 : 0);
	endtask
	task automatic rst_chk();
		ex = '{PBCM_RST_BRIDGE_B, PBCM_RST_BRIDGE_C, PBCM_RST_BRIDGE_D};
		foreach (ex[k])
		begin
			apb(0, PBCM_OFS_BRIDGE_B + 12'(4 * k), 32'h0);
			cmp(rd, ex[k]);
		end
		gates();
	endtask
	task automatic close_out();
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		rst_chk();
		foreach (rows[i])
		begin
			apb(1, rows[i].a, rows[i].d);
			cmp(32'(er), 32'(rows[i].e));
			apb(0, rows[i].a, 32'h0);
			cmp(rd, rows[i].r);
			cmp(32'(er), 32'(rows[i].e));
			if (!rows[i].e)
				ex[(rows[i].a - PBCM_OFS_BRIDGE_B) >> 2] = rows[i].d;
			gates();
		end
		foreach (ex[k])
			apb(1, PBCM_OFS_BRIDGE_B + 12'(4 * k), 32'h0);
		ex = '{32'h0, 32'h0, 32'h0};
		gates();
		@(posedge pclk);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rst_chk();
		close_out();
	end
	initial
	begin
		#4000;
		err_total++;
		close_out();
	end
endmodule // pbcm_tb_top
bind pbcm_top pbcm_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .periph_clk, .periph_clk_en);
`default_nettype wire
